/* File: src/pcz_ctrl.sv */
// control register zero with mode, cache, trap and fpu error steering
`timescale 1ns/1ps
// What this block does
// R01: ten defined bits, others read zero
// R02: mode decoded from paging and protection
// R03: paging without protection faults, code zero
// R04: fill and write-through disables follow bits
// R05: fills on with no write-through faults
// R06: install fill only when all enables allow
// R07: cache fill disable set at reset
// R08: write-through mode: writes out, invalidates remove
// R09: no write-through: hits stay, invalidates ignored
// R10: fp and wait trap to vector seven
// R11: status word access touches low bits only
// R12: alignment faults gated by alignment mask
// R13: supervisor write protect faults all levels
// R14: error output active on any unmasked exception
// R15: external mode freezes at next fp instruction
// R16: ignore input active lets execution continue
// R17: control instructions never freeze, wait does
// R18: outside controller supplies vector on error
// R19: native mode takes vector sixteen, ignores pin
// R20: native error reporting cleared at reset
// R21: task switch sets task switched bit
// R22: protection, monitor, emulate at bits 0..2
// R23: new value governs all following instructions
module pcz_ctrl (
   // clock and reset
   input  wire logic               i_mclk,
   input  wire logic               i_sys_rst,
   input  wire logic               i_ce,
   // register access
   input  wire logic               i_cr_wr,
   input  wire logic               i_msw_wr,
   input  wire logic [31:0]        i_wdata,
   output logic      [31:0]        o_cr_rdata,
   output logic      [15:0]        o_msw_rdata,
   output logic                    o_general_protection_fault,
   output logic      [15:0]        o_gp_code,
   output pcz_pkg::pcz_mode_t      o_mode,
   // task switch
   input  wire logic               i_task_switch,
   // instruction stream
   input  wire logic               i_ins_valid,
   input  wire pcz_pkg::pcz_ins_t  i_ins_kind,
   output logic                    o_trap,
   output logic      [7:0]         o_trap_vec,
   output logic                    o_freeze,
   // fpu error
   input  wire logic               i_fpu_exc,
   input  wire logic               i_fpu_exc_clr,
   input  wire logic               i_ignore_fpu_error_in_n,
   output logic                    o_fpu_error_out_n,
   // cache
   input  wire logic               i_fill_req,
   input  wire logic               i_cache_line_enable_in_n,
   input  wire logic               i_page_uncacheable,
   input  wire logic               i_wr_req,
   input  wire logic               i_wr_hit,
   input  wire logic               i_inval_req,
   input  wire logic               i_inval_hit,
   output logic                    o_fill_install,
   output logic                    o_ext_write,
   output logic                    o_hit_update,
   output logic                    o_inval_remove,
   // memory checks
   input  wire logic               i_misaligned,
   input  wire logic               i_alignment_check_flag,
   input  wire logic               i_ro_write,
   input  wire logic [1:0]         i_cpl,
   output logic                    o_align_fault,
   output logic                    o_wp_fault
);
   import pcz_pkg::*;

   // ----------------------------------------
   // register and write checks
   // ----------------------------------------
   logic [31:0] cr_q;
   logic [31:0] cand;
   logic        wr_any;
   logic        bad_pg;
   logic        bad_cache;
   logic        wr_ok;
   logic        ts_set;
   logic        ken_s1_q, ken_s2_q;
   logic        ign_s1_q, ign_s2_q;
   logic        pend_q;

   // low word only for status word loads
   always_comb begin
      cand = cr_q;
      if (i_cr_wr) begin
         cand = i_wdata & PCZ_DEF_MASK; // see R01
      end else if (i_msw_wr) begin
         cand[PCZ_MSW_W-1:0] = (cr_q[PCZ_MSW_W-1:0] & ~PCZ_MSW_MASK)
                             | (i_wdata[PCZ_MSW_W-1:0] & PCZ_MSW_MASK); // see R11
      end
   end

   assign wr_any    = i_cr_wr | i_msw_wr;
   assign bad_pg    = cand[PCZ_PG_BIT] & ~cand[PCZ_PE_BIT]; // see R03
   assign bad_cache = ~cand[PCZ_CD_BIT] & cand[PCZ_NW_BIT]; // see R05
   assign wr_ok     = wr_any & ~bad_pg & ~bad_cache;
   assign ts_set    = i_task_switch;

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         cr_q <= PCZ_RST_VAL; // see R07 see R20
      end else if (i_ce) begin
         if (wr_ok) begin
            cr_q <= cand; // see R23
         end
         if (ts_set) begin
            cr_q[PCZ_TS_BIT] <= 1'b1; // see R21
         end
      end
   end

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_general_protection_fault <= 1'b0;
         o_gp_code  <= PCZ_GP_CODE;
      end else if (i_ce) begin
         o_general_protection_fault <= wr_any & (bad_pg | bad_cache); // see R03 see R05
         o_gp_code  <= PCZ_GP_CODE;
      end
   end

   assign o_cr_rdata  = cr_q;
   assign o_msw_rdata = cr_q[PCZ_MSW_W-1:0]; // see R11
   assign o_mode      = pcz_mode_t'({cr_q[PCZ_PG_BIT], cr_q[PCZ_PE_BIT]}); // see R02 see R22

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         ken_s1_q <= 1'b1;
         ken_s2_q <= 1'b1;
         ign_s1_q <= 1'b1;
         ign_s2_q <= 1'b1;
      end else if (i_ce) begin
         ken_s1_q <= i_cache_line_enable_in_n;
         ken_s2_q <= ken_s1_q;
         ign_s1_q <= i_ignore_fpu_error_in_n;
         ign_s2_q <= ign_s1_q;
      end
   end

   // ----------------------------------------
   // cache policy
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_fill_install <= 1'b0;
         o_ext_write    <= 1'b0;
         o_hit_update   <= 1'b0;
         o_inval_remove <= 1'b0;
      end else if (i_ce) begin
         // pin low means fill permitted
         o_fill_install <= i_fill_req & ~cr_q[PCZ_CD_BIT] & ~ken_s2_q
                           & ~i_page_uncacheable; // see R04 see R06
         o_ext_write    <= i_wr_req & (~cr_q[PCZ_NW_BIT] | ~i_wr_hit); // see R08 see R09
         o_hit_update   <= i_wr_req & i_wr_hit;
         o_inval_remove <= i_inval_req & i_inval_hit & ~cr_q[PCZ_NW_BIT]; // see R08 see R09
      end
   end

   // ----------------------------------------
   // alignment and write protect
   // ----------------------------------------
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_align_fault <= 1'b0;
         o_wp_fault    <= 1'b0;
      end else if (i_ce) begin
         o_align_fault <= i_misaligned & i_alignment_check_flag
                          & cr_q[PCZ_AM_BIT]; // see R12
         o_wp_fault    <= i_ro_write & (cr_q[PCZ_WP_BIT]
                          | (i_cpl == PCZ_CPL_USER)); // see R13
      end
   end

   // ----------------------------------------
   // fpu traps and error reporting
   // ----------------------------------------
   logic is_fp, is_wait, dna, err_hit;

   assign is_fp   = i_ins_valid & (i_ins_kind == PCZ_INS_FP);
   assign is_wait = i_ins_valid & (i_ins_kind == PCZ_INS_WAIT);
   assign dna     = (is_fp & (cr_q[PCZ_EM_BIT] | cr_q[PCZ_TS_BIT]))
                  | (is_wait & cr_q[PCZ_TS_BIT] & cr_q[PCZ_MP_BIT]); // see R10
   // control instructions never reach the error check
   assign err_hit = pend_q & (is_fp | is_wait) & ~dna; // see R17

   // set wins over clear
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         pend_q <= 1'b0;
      end else if (i_ce) begin
         if (i_fpu_exc) begin
            pend_q <= 1'b1;
         end else if (i_fpu_exc_clr) begin
            pend_q <= 1'b0;
         end
      end
   end

   assign o_fpu_error_out_n = ~pend_q; // see R14 see R18

   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_trap     <= 1'b0;
         o_trap_vec <= PCZ_VEC_DNA;
         o_freeze   <= 1'b0;
      end else if (i_ce) begin
         o_trap <= 1'b0;
         if (dna) begin
            o_trap     <= 1'b1; // see R10
            o_trap_vec <= PCZ_VEC_DNA;
         end else if (err_hit & cr_q[PCZ_NE_BIT]) begin
            o_trap     <= 1'b1; // see R19
            o_trap_vec <= PCZ_VEC_MF;
         end
         // freeze holds until cleared, ignored or native mode set
         if (~pend_q | ~ign_s2_q | cr_q[PCZ_NE_BIT]) begin
            o_freeze <= 1'b0; // see R16
         end else if (err_hit) begin
            o_freeze <= 1'b1; // see R15
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_sys_rst);

   sequence s_bad_load;
      i_ce && wr_any && (bad_pg || bad_cache);
   endsequence
   sequence s_held;
      $stable(cr_q) || $rose(cr_q[PCZ_TS_BIT]);
   endsequence

   chk_bad_load_faults: assert property (s_bad_load |=> o_general_protection_fault && o_gp_code == 16'h0000 ##0 s_held) // see R03 see R05
      else $error("bad load not faulted or register changed");
   chk_reserved_zero: assert property ((cr_q & ~PCZ_DEF_MASK) == 32'h0000_0000) // see R01
      else $error("undefined bit set");
   chk_mode_decode: assert property (o_mode != PCZ_MODE_RSVD) // see R02
      else $error("reserved mode reached");
   chk_fill_gate: assert property ( // see R06
         o_fill_install |-> !$past(cr_q[PCZ_CD_BIT]) && !$past(ken_s2_q)
         && !$past(i_page_uncacheable))
      else $error("fill installed while disabled");
   chk_hit_no_bus: assert property (i_ce && i_wr_req && i_wr_hit && cr_q[PCZ_NW_BIT] |=> !o_ext_write) // see R09
      else $error("write hit reached bus");
   chk_wt_all_out: assert property (i_ce && i_wr_req && !cr_q[PCZ_NW_BIT] |=> o_ext_write) // see R08
      else $error("write-through write missing");
   chk_ts_on_switch: assert property (i_ce && i_task_switch |=> cr_q[PCZ_TS_BIT]) // see R21
      else $error("task switched not set");
   chk_msw_upper: assert property (i_ce && i_msw_wr && !i_cr_wr |=> cr_q[31:PCZ_MSW_W] == $past(cr_q[31:PCZ_MSW_W])) // see R11
      else $error("status word load hit upper bits");
   chk_wait_trap: assert property (i_ce && is_wait && cr_q[PCZ_TS_BIT] && cr_q[PCZ_MP_BIT] |=> o_trap && o_trap_vec == 8'h07) // see R10
      else $error("wait trap missed");
   chk_err_pin: assert property (i_ce && i_fpu_exc |=> !o_fpu_error_out_n) // see R14
      else $error("error output not driven");
   chk_native_int: assert property (i_ce && err_hit && !dna && cr_q[PCZ_NE_BIT] |=> o_trap && o_trap_vec == 8'h10 && !o_freeze) // see R19
      else $error("native error vector missed");
   chk_freeze_ext: assert property (i_ce && err_hit && !cr_q[PCZ_NE_BIT] && !ign_s2_q |=> !o_freeze) // see R16
      else $error("froze while ignore active");
   chk_no_fctl_freeze: assert property (i_ce && !o_freeze && i_ins_valid && i_ins_kind == PCZ_INS_FCTL |=> !o_freeze) // see R17
      else $error("control instruction froze");

   // ----------------------------------------
   // register, cache, memory, trap and freeze checks
   // ----------------------------------------
   sequence s_good_load;
      i_ce && i_cr_wr && !bad_pg && !bad_cache && !i_task_switch;
   endsequence

   chk_good_load: assert property (s_good_load |=> cr_q == $past(cand)) // see R23
      else $error("accepted load not applied");
   chk_no_gp_good: assert property ( // see R03 see R05
         i_ce && wr_any && !bad_pg && !bad_cache |=> !o_general_protection_fault)
      else $error("good load faulted");
   chk_fill_cd_off: assert property ( // see R04
         i_ce && i_fill_req && cr_q[PCZ_CD_BIT] |=> !o_fill_install)
      else $error("fill while disabled");
   chk_inval_ignored: assert property ( // see R09
         i_ce && i_inval_req && cr_q[PCZ_NW_BIT] |=> !o_inval_remove)
      else $error("invalidate not ignored");
   chk_inval_removes: assert property ( // see R08
         i_ce && i_inval_req && i_inval_hit && !cr_q[PCZ_NW_BIT] |=> o_inval_remove)
      else $error("invalidate hit kept line");
   chk_miss_to_bus: assert property ( // see R09
         i_ce && i_wr_req && !i_wr_hit |=> o_ext_write)
      else $error("write miss not sent out");
   chk_align_gate: assert property ( // see R12
         i_ce && i_misaligned && i_alignment_check_flag
         |=> o_align_fault == $past(cr_q[PCZ_AM_BIT]))
      else $error("alignment fault not gated by mask");
   chk_wp_forced: assert property ( // see R13
         i_ce && i_ro_write && cr_q[PCZ_WP_BIT] |=> o_wp_fault)
      else $error("write protect fault missed");
   chk_wp_super_ok: assert property ( // see R13
         i_ce && i_ro_write && !cr_q[PCZ_WP_BIT] && i_cpl != PCZ_CPL_USER |=> !o_wp_fault)
      else $error("supervisor write faulted");
   chk_fp_trap: assert property ( // see R10
         i_ce && is_fp && (cr_q[PCZ_EM_BIT] || cr_q[PCZ_TS_BIT])
         |=> o_trap && o_trap_vec == 8'h07)
      else $error("fp trap missed");
   chk_wait_no_trap: assert property ( // see R10
         i_ce && is_wait && !(cr_q[PCZ_TS_BIT] && cr_q[PCZ_MP_BIT])
         |=> !(o_trap && o_trap_vec == 8'h07))
      else $error("wait trapped without monitor");
   chk_freeze_on_err: assert property ( // see R15
         i_ce && err_hit && ign_s2_q && !cr_q[PCZ_NE_BIT] |=> o_freeze)
      else $error("no freeze on pending error");
endmodule : pcz_ctrl

/* File: src/pcz_pkg.sv */
// constants and types shared by the control register zero block
package pcz_pkg;
   // bit positions
   localparam int PCZ_PE_BIT = 0;
   localparam int PCZ_MP_BIT = 1;
   localparam int PCZ_EM_BIT = 2;
   localparam int PCZ_TS_BIT = 3;
   localparam int PCZ_NE_BIT = 5;
   localparam int PCZ_WP_BIT = 16;
   localparam int PCZ_AM_BIT = 18;
   localparam int PCZ_NW_BIT = 29;
   localparam int PCZ_CD_BIT = 30;
   localparam int PCZ_PG_BIT = 31;
   localparam int PCZ_MSW_W  = 16;
   // defined bits and reset value
   localparam logic [31:0] PCZ_DEF_MASK  = 32'hE005_002F;
   localparam logic [31:0] PCZ_RST_VAL   = 32'h4000_0000;
   localparam logic [15:0] PCZ_MSW_MASK  = 16'h000F;
   // vectors and codes
   localparam logic [7:0]  PCZ_VEC_DNA   = 8'h07;
   localparam logic [7:0]  PCZ_VEC_MF    = 8'h10;
   localparam logic [15:0] PCZ_GP_CODE   = 16'h0000;
   localparam logic [1:0]  PCZ_CPL_USER  = 2'h3;

   typedef enum logic [1:0] {
      PCZ_MODE_REAL  = 2'b00,
      PCZ_MODE_PROT  = 2'b01,
      PCZ_MODE_RSVD  = 2'b10,
      PCZ_MODE_PAGED = 2'b11
   } pcz_mode_t;

   typedef enum logic [1:0] {
      PCZ_INS_OTHER = 2'b00,
      PCZ_INS_FP    = 2'b01,
      PCZ_INS_WAIT  = 2'b10,
      PCZ_INS_FCTL  = 2'b11
   } pcz_ins_t;
endpackage : pcz_pkg

/* File: tb/pcz_ctrl_tb_top.sv */
// self-checking bench for the control register zero block
`timescale 1ns/1ps
module pcz_ctrl_tb_top;
   import pcz_pkg::*;
   typedef struct {int k; logic [31:0] e; string n;} pcz_note_t;
   logic i_mclk = 0, i_sys_rst = 1, i_ce = 1, i_cr_wr, i_msw_wr, i_task_switch;
   logic i_ins_valid, i_fpu_exc, i_fpu_exc_clr, i_ignore_fpu_error_in_n, i_fill_req;
   logic i_cache_line_enable_in_n, i_page_uncacheable, i_wr_req, i_wr_hit, i_inval_req;
   logic i_inval_hit, i_misaligned, i_alignment_check_flag, i_ro_write, ign_req, bad;
   logic o_general_protection_fault, o_trap, o_freeze, o_fpu_error_out_n, o_fill_install, o_ext_write;
   logic o_hit_update, o_inval_remove, o_align_fault, o_wp_fault;
   logic [1:0]  i_cpl;
   logic [31:0] i_wdata, o_cr_rdata, cr;
   logic [15:0] o_msw_rdata, o_gp_code;
   logic [7:0]  o_trap_vec, pic_vec;
   pcz_ins_t    i_ins_kind;
   pcz_mode_t   o_mode;
   int          fails = 0, tests_run = 0;
   pcz_note_t   q[$];
   pcz_note_t   m;
   event        ev;

   pcz_ctrl DUT (
      .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_cr_wr(i_cr_wr),
      .i_msw_wr(i_msw_wr), .i_wdata(i_wdata), .o_cr_rdata(o_cr_rdata),
      .o_msw_rdata(o_msw_rdata), .o_general_protection_fault(o_general_protection_fault), .o_gp_code(o_gp_code),
      .o_mode(o_mode), .i_task_switch(i_task_switch), .i_ins_valid(i_ins_valid),
      .i_ins_kind(i_ins_kind), .o_trap(o_trap), .o_trap_vec(o_trap_vec), .o_freeze(o_freeze),
      .i_fpu_exc(i_fpu_exc), .i_fpu_exc_clr(i_fpu_exc_clr),
      .i_ignore_fpu_error_in_n(i_ignore_fpu_error_in_n),
      .o_fpu_error_out_n(o_fpu_error_out_n),
      .i_fill_req(i_fill_req), .i_cache_line_enable_in_n(i_cache_line_enable_in_n),
      .i_page_uncacheable(i_page_uncacheable), .i_wr_req(i_wr_req), .i_wr_hit(i_wr_hit),
      .i_inval_req(i_inval_req), .i_inval_hit(i_inval_hit), .o_fill_install(o_fill_install),
      .o_ext_write(o_ext_write), .o_hit_update(o_hit_update), .o_inval_remove(o_inval_remove),
      .i_misaligned(i_misaligned), .i_alignment_check_flag(i_alignment_check_flag),
      .i_ro_write(i_ro_write), .i_cpl(i_cpl), .o_align_fault(o_align_fault),
      .o_wp_fault(o_wp_fault));
   pcz_pic_model PIC (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst),
      .i_fpu_error_out_n(o_fpu_error_out_n), .i_ignore_req(ign_req),
      .o_ignore_fpu_error_in_n(i_ignore_fpu_error_in_n), .o_vec(pic_vec));

   always #12.5 i_mclk = ~i_mclk;

   // ----------------------------------------
   // observation and comparison
   // ----------------------------------------
   function automatic logic [31:0] probe(int k);
      case (k)
         0: return o_cr_rdata;
         1: return {15'h0, o_general_protection_fault, o_gp_code};
         2: return {30'h0, o_mode};
         3: return {31'h0, o_trap};
         4: return {30'h0, o_freeze, o_fpu_error_out_n};
         5: return {29'h0, o_fill_install, o_ext_write, o_inval_remove};
         6: return {30'h0, o_align_fault, o_wp_fault};
         7: return {16'h0, o_msw_rdata};
         8: return {24'h0, pic_vec};
         9: return {24'h0, o_trap_vec};
         default: return {31'h0, o_hit_update};
      endcase
   endfunction : probe

   task automatic check(logic [31:0] seen, logic [31:0] exp, string n);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", n, exp, seen);
      end
   endtask : check

   task automatic note(int k, logic [31:0] e, string n);
      q.push_back('{k, e, n});
   endtask : note

   // queued notes compared, oldest first, once the taking edge has settled
   always begin
      @ev;
      while (q.size() > 0) begin
         m = q.pop_front();
         check(probe(m.k), m.e, m.n);
      end
   end

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report

   // ----------------------------------------
   // drivers
   // ----------------------------------------
   task automatic op;
      @(posedge i_mclk);
      #1;
      {i_cr_wr, i_msw_wr, i_task_switch, i_ins_valid, i_fpu_exc, i_fpu_exc_clr} = '0;
      {i_fill_req, i_wr_req, i_inval_req} = '0;
      ->ev;
      @(posedge i_mclk);
      #1;
   endtask : op

   task automatic wr(logic [31:0] d);
      bad = (d[31] & ~d[0]) | (~d[30] & d[29]);
      if (!bad) begin
         cr = d & 32'hE005_002F;
      end
      i_wdata = d;
      i_cr_wr = 1;
      note(0, cr, "cr");
      note(1, {15'h0, bad, 16'h0000}, "gp");
      note(2, {30'h0, cr[31], cr[0]}, "mode");
      op;
   endtask : wr

   task automatic ins(pcz_ins_t k);
      i_ins_valid = 1;
      i_ins_kind = k;
   endtask : ins

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      {i_cr_wr, i_msw_wr, i_task_switch, i_ins_valid, i_fpu_exc, i_fpu_exc_clr, bad} = '0;
      {i_fill_req, i_page_uncacheable, i_wr_req, i_wr_hit, i_inval_req, i_inval_hit} = '0;
      {i_misaligned, i_alignment_check_flag, i_ro_write, ign_req} = '0;
      i_cache_line_enable_in_n = 0;
      i_cpl = 2'h0;
      i_wdata = 32'h0000_0000;
      i_ins_kind = PCZ_INS_OTHER;
      cr = 32'h4000_0000;
      void'($urandom(17));
      repeat (16) @(posedge i_mclk);
      #1;
      i_sys_rst = 0;
      note(0, 32'h4000_0000, "rst cr");
      note(4, 32'h0000_0001, "rst err");
      op;
      for (int i = 0; i < 40; i++) wr($urandom());
      wr(32'h4000_0021);
      i_wdata = 32'h0000_FFFE;
      i_msw_wr = 1;
      note(0, 32'h4000_002E, "msw load");
      note(7, 32'h0000_002E, "msw read");
      op;
      wr(32'h4000_0000);
      i_task_switch = 1;
      note(0, 32'h4000_0008, "ts set");
      op;
      $display("test register done");
      for (int i = 0; i < 8; i++) begin
         wr({28'h400_0000, i[1], i[2], i[0], 1'b1});
         ins(PCZ_INS_FP);
         note(3, {31'h0, i[2] | i[1]}, "fp trap");
         op;
         ins(PCZ_INS_WAIT);
         note(3, {31'h0, i[1] & i[0]}, "wait trap");
         op;
         ins(PCZ_INS_FCTL);
         note(3, 32'h0, "ctl trap");
         op;
      end
      note(9, 32'h0000_0007, "dna vec");
      op;
      $display("test traps done");
      wr(32'h4000_0020);
      i_fpu_exc = 1;
      ign_req = 1;
      note(4, 32'h0, "err out");
      op;
      ins(PCZ_INS_FCTL);
      note(3, 32'h0, "ctl no mf");
      op;
      ins(PCZ_INS_FP);
      note(3, 32'h1, "mf trap");
      note(9, 32'h0000_0010, "mf vec");
      op;
      i_fpu_exc_clr = 1;
      ign_req = 0;
      op;
      wr(32'h4000_0000);
      i_fpu_exc = 1;
      op;
      ins(PCZ_INS_FCTL);
      note(4, 32'h0, "ctl no freeze");
      note(8, 32'h0000_000D, "pic vec");
      op;
      ins(PCZ_INS_FP);
      note(4, 32'h2, "freeze");
      op;
      i_fpu_exc_clr = 1;
      for (int n = 0; n < 8 && o_freeze !== 1'b0; n++) op;
      if (o_freeze !== 1'b0) begin
         fails++;
         final_report;
      end
      ign_req = 1;
      op;
      i_fpu_exc = 1;
      op;
      ins(PCZ_INS_FP);
      note(4, 32'h0, "ignored");
      op;
      $display("test fpu error done");
      for (int i = 0; i < 4; i++) begin
         i_page_uncacheable = (i == 1);
         i_cache_line_enable_in_n = (i == 2);
         wr({1'b0, i == 3, 30'h0});
         op;
         i_fill_req = 1;
         note(5, {29'h0, i == 0, 2'b00}, "fill");
         op;
      end
      for (int i = 0; i < 4; i++) begin
         wr({2'b01, i[1], 29'h0});
         {i_wr_req, i_inval_req, i_inval_hit, i_wr_hit} = {3'b111, i[0]};
         note(5, {30'h0, !(i[1] & i[0]), !i[1]}, "wt");
         note(10, {31'h0, i[0]}, "hit update");
         op;
      end
      {i_misaligned, i_alignment_check_flag, i_ro_write} = 3'b111;
      for (int i = 0; i < 8; i++) begin
         wr({13'h0800, i[0], 1'b0, i[1], 16'h0000});
         i_cpl = i[2] ? 2'h3 : 2'h0;
         note(6, {30'h0, i[0], i[1] | i[2]}, "align wp");
         op;
      end
      $display("test cache and memory done");
      final_report;
   end
endmodule : pcz_ctrl_tb_top

/* File: tb/pcz_pic_model.sv */
// model of the outside interrupt controller on the fpu error pins
`timescale 1ns/1ps
module pcz_pic_model #(
   parameter logic [7:0] VEC = 8'h0D
) (
   // clock and reset
   input  wire logic       i_mclk,
   input  wire logic       i_sys_rst,
   // error pins
   input  wire logic       i_fpu_error_out_n,
   input  wire logic       i_ignore_req,
   output logic            o_ignore_fpu_error_in_n,
   // vector towards the core
   output logic      [7:0] o_vec
);
   assign o_ignore_fpu_error_in_n = ~i_ignore_req;
   always_ff @(posedge i_mclk) begin
      if (i_sys_rst) begin
         o_vec <= 8'h00;
      end else begin
         o_vec <= i_fpu_error_out_n ? 8'h00 : VEC;
      end
   end
endmodule : pcz_pic_model
